// >>> mesc_phy_model.sv
`default_nettype none
module mesc_phy_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic tx_en_in,
   input wire logic [1:0] crs_mode_in,
   input wire logic sqe_col_in,
   input wire logic rx_go_in,
   input wire logic rx_bad_in,
   output logic crs_out,
   output logic col_out,
   output logic rx_dv_out,
   output logic rx_er_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic tx_d_r; // Last cycle's transmit enable
   logic [3:0] gap_r; // Cycles since transmit ended
   // Track the end of each transmit burst
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_d_r <= 1'b0;
         gap_r <= 4'h0;
      end else begin
         tx_d_r <= tx_en_in;
         if (tx_d_r && !tx_en_in) begin
            gap_r <= 4'h1;
         end else if (gap_r != 4'h0) begin
            gap_r <= gap_r + 4'h1;
         end
      end
   end
   // Carrier held one cycle past the burst, absent, or lost after one cycle
   assign crs_out = tx_en_in ? (crs_mode_in == 2'b01 || (crs_mode_in == 2'b10 && !tx_d_r))
      : (crs_mode_in == 2'b01 && tx_d_r);
   // Heartbeat collision five cycles after transmit ends, unless told to omit it
   assign col_out = sqe_col_in && gap_r == 4'h5;
   assign rx_dv_out = rx_go_in;
   assign rx_er_out = rx_go_in && rx_bad_in;
endmodule : mesc_phy_model
`default_nettype wire

// >>> mesc_pkg.sv
`default_nettype none
package mesc_pkg;
   // Counter slots in the register map, one word each
   localparam int NUM_CNT = 9;
   localparam int IDX_TX_UNDERRUN = 0;
   localparam int IDX_CARRIER_ERR = 1;
   localparam int IDX_RX_RESOURCE = 2;
   localparam int IDX_RX_OVERRUN = 3;
   localparam int IDX_RX_SYMBOL = 4;
   localparam int IDX_EXCESS_LEN = 5;
   localparam int IDX_RX_JABBER = 6;
   localparam int IDX_UNDERSIZE = 7;
   localparam int IDX_SQE_TEST = 8;
   // Byte addresses
   localparam logic [7:0] OFF_TX_UNDERRUN_COUNT = 8'h00;
   localparam logic [7:0] OFF_CARRIER_SENSE_ERROR_COUNT = 8'h04;
   localparam logic [7:0] OFF_RX_RESOURCE_ERROR_COUNT = 8'h08;
   localparam logic [7:0] OFF_RX_OVERRUN_COUNT = 8'h0c;
   localparam logic [7:0] OFF_RX_SYMBOL_ERROR_COUNT = 8'h10;
   localparam logic [7:0] OFF_EXCESS_LENGTH_COUNT = 8'h14;
   localparam logic [7:0] OFF_RX_JABBER_COUNT = 8'h18;
   localparam logic [7:0] OFF_UNDERSIZE_FRAME_COUNT = 8'h1c;
   localparam logic [7:0] OFF_SQE_TEST_ERROR_COUNT = 8'h20;
   localparam logic [7:0] OFF_CONFIG = 8'h24;
   localparam logic [7:0] OFF_INT_STATUS = 8'h28;
   localparam logic [7:0] OFF_INT_MASK = 8'h2c;
   // Counter widths
   localparam int CNT_W_MAX = 16;
   localparam int CNT_W_NARROW = 8;
   localparam int CNT_W_RESOURCE = 16;
   // Config register fields
   localparam int CFG_FULL_DUPLEX_BIT = 0;
   localparam int CFG_SPEED_100_BIT = 1;
   localparam int CFG_BIG_FRAMES_BIT = 8;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_WR_MASK = 32'h0000_0103;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [8:0] INT_RESET = 9'h000;
   // Frame length limits in bytes
   localparam int LEN_W = 14;
   localparam logic [LEN_W-1:0] LEN_MIN = 14'd64;
   localparam logic [LEN_W-1:0] LEN_MAX_STD = 14'd1518;
   localparam logic [LEN_W-1:0] LEN_MAX_BIG = 14'd1536;
   // SQE window timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SQE_BIT_TIMES = 96;
   localparam int BIT_TIME_100_NS = 10;
   localparam int BIT_TIME_10_NS = 100;
   localparam int SQE_WIN_100_NS = SQE_BIT_TIMES * BIT_TIME_100_NS;
   localparam int SQE_WIN_10_NS = SQE_BIT_TIMES * BIT_TIME_10_NS;
   localparam int SQE_CYC_100 = SQE_WIN_100_NS / CLK_PERIOD_NS;
   localparam int SQE_CYC_10 = SQE_WIN_10_NS / CLK_PERIOD_NS;
   localparam int SQE_CNT_W = 10;

   // MII signals watched by the counters
   typedef struct packed {
      logic tx_en;
      logic crs;
      logic col;
      logic rx_dv;
      logic rx_er;
   } mesc_mii_t;

   // End of a transmitted frame
   typedef struct packed {
      logic frame_end;
      logic underrun;
   } mesc_tx_stat_t;

   // End of a received frame
   typedef struct packed {
      logic frame_end;
      logic addr_match;
      logic no_buffer;
      logic overrun;
      logic crc_err;
      logic align_err;
      logic [LEN_W-1:0] length;
   } mesc_rx_stat_t;

   // SQE window tracker states
   typedef enum logic [2:0] {
      SQE_IDLE = 3'b001,
      SQE_TX = 3'b010,
      SQE_WAIT = 3'b100
   } mesc_sqe_state_t;
endpackage : mesc_pkg
`default_nettype wire

// >>> mesc_top.sv
// The implementer's own choices: the register offsets and the APB register port.
`default_nettype none
module mesc_top (
   input wire logic clk_in,
   input wire logic rst_n_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Frame and MII inputs
   input wire mesc_pkg::mesc_mii_t mii_in,
   input wire mesc_pkg::mesc_tx_stat_t tx_stat_in,
   input wire mesc_pkg::mesc_rx_stat_t rx_stat_in,
   // Requests to the FCS and alignment counters elsewhere
   output logic fcs_err_inc_out,
   output logic align_err_inc_out,
   // Interrupt
   output logic irq_out
);
   import mesc_pkg::*;

   // Width mask of a counter slot
   function automatic logic [15:0] cnt_mask(input int idx);
      // Resource counter is the only wide one
      if (idx == IDX_RX_RESOURCE) begin
         cnt_mask = 16'hffff;
      end else begin
         cnt_mask = 16'h00ff;
      end
   endfunction : cnt_mask

   // Reset synchroniser
   logic rst_meta_r;
   logic rst_n_r;
   // Configuration, interrupt status and mask
   logic [31:0] cfg_r;
   logic [8:0] int_stat_r;
   logic [8:0] int_mask_r;
   // Counter store
   logic [15:0] cnt_r [NUM_CNT];
   // One-cycle increment requests
   logic [8:0] inc;
   // Bus decode
   logic apb_access;
   logic apb_wr;
   logic apb_rd;
   logic [3:0] word_idx;
   logic addr_hit;
   // Mode bits
   logic half_duplex;
   logic [LEN_W-1:0] len_max;
   // Transmit tracking flags
   logic tx_en_d_r;
   logic crs_seen_r;
   logic crs_drop_r;
   logic col_seen_r;
   logic tx_urun_r;
   logic crs_seen_now;
   logic crs_drop_now;
   logic col_seen_now;
   logic carrier_err_event;
   logic underrun_event;
   // SQE window
   mesc_sqe_state_t sqe_state_r;
   logic [SQE_CNT_W-1:0] sqe_cnt_r;
   logic [SQE_CNT_W-1:0] sqe_limit;
   logic sqe_event;
   // Receive tracking
   logic sym_r;
   logic sym_now;
   logic rx_long;
   logic rx_short;
   logic rx_bad;
   logic rx_valid_len;
   logic fcs_inc_nxt;
   logic align_inc_nxt;

   // Two-stage reset release
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // Zero-wait APB decode
   assign apb_access = psel_in && penable_in;
   assign apb_wr = apb_access && pwrite_in;
   assign apb_rd = apb_access && !pwrite_in;
   // Word index of the slot being accessed
   assign word_idx = paddr_in[5:2];
   // Aligned words up to the mask register are mapped
   assign addr_hit = (paddr_in[1:0] == 2'b00) && (paddr_in <= OFF_INT_MASK);
   // Every access completes without wait states
   assign pready_out = 1'b1;
   // Unmapped or misaligned access is refused
   assign pslverr_out = apb_access && !addr_hit;

   // Mode bits from config
   assign half_duplex = !cfg_r[CFG_FULL_DUPLEX_BIT];
   assign len_max = cfg_r[CFG_BIG_FRAMES_BIT] ? LEN_MAX_BIG : LEN_MAX_STD;
   // Window length in clocks for the line rate
   assign sqe_limit = cfg_r[CFG_SPEED_100_BIT] ? SQE_CNT_W'(SQE_CYC_100)
                                               : SQE_CNT_W'(SQE_CYC_10);

   // Config register
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cfg_r <= CFG_RESET;
      end else if (apb_wr && addr_hit && paddr_in == OFF_CONFIG) begin
         // Only the defined bits take a write
         cfg_r <= pwdata_in & CFG_WR_MASK;
      end
   end

   // Carrier and collision state including this cycle
   // Carrier seen at any point of this frame
   assign crs_seen_now = crs_seen_r || (mii_in.tx_en && mii_in.crs);
   // Carrier lost after it had been seen
   assign crs_drop_now = crs_drop_r || (mii_in.tx_en && crs_seen_r && !mii_in.crs);
   // Collision during the frame itself, not the heartbeat
   assign col_seen_now = col_seen_r || (mii_in.tx_en && mii_in.col);

   // Per-frame transmit flags, cleared when tx_en rises
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tx_en_d_r <= 1'b0;
         crs_seen_r <= 1'b0;
         crs_drop_r <= 1'b0;
         col_seen_r <= 1'b0;
         tx_urun_r <= 1'b0;
      end else begin
         // Edge history for frame start
         tx_en_d_r <= mii_in.tx_en;
         if (mii_in.tx_en && !tx_en_d_r) begin
            // New frame starts
            crs_seen_r <= mii_in.crs;
            crs_drop_r <= 1'b0;
            col_seen_r <= mii_in.col;
            tx_urun_r <= 1'b0;
         end else begin
            crs_seen_r <= crs_seen_now;
            crs_drop_r <= crs_drop_now;
            col_seen_r <= col_seen_now;
            // Remember an underrun until the next frame
            if (tx_stat_in.frame_end && tx_stat_in.underrun) begin
               tx_urun_r <= 1'b1;
            end
         end
      end
   end

   // Underrun frame event
   // Status is valid only with the end-of-frame pulse
   assign underrun_event = tx_stat_in.frame_end && tx_stat_in.underrun;

   // Carrier never seen or lost, no collision
   // Suppressed by underrun
   // Flags still describe the frame after tx_en drops
   assign carrier_err_event = tx_stat_in.frame_end && !tx_stat_in.underrun && half_duplex
                              && !col_seen_now && (!crs_seen_now || crs_drop_now);

   // SQE window tracker
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sqe_state_r <= SQE_IDLE;
         sqe_cnt_r <= '0;
      end else begin
         unique case (sqe_state_r)
            SQE_IDLE: begin
               // Wait for a transmit
               if (mii_in.tx_en) begin
                  sqe_state_r <= SQE_TX;
               end
            end
            SQE_TX: begin
               // Open the window when tx_en drops in half duplex
               if (!mii_in.tx_en) begin
                  // Count restarts for each window
                  sqe_cnt_r <= '0;
                  sqe_state_r <= half_duplex ? SQE_WAIT : SQE_IDLE;
               end
            end
            SQE_WAIT: begin
               // Leave on col, timeout or a new frame
               if (mii_in.col || sqe_event) begin
                  sqe_state_r <= mii_in.tx_en ? SQE_TX : SQE_IDLE;
               end else if (mii_in.tx_en) begin
                  // A new frame aborts the window uncounted
                  sqe_state_r <= SQE_TX;
               end else begin
                  // Quiet cycle, advance the window
                  sqe_cnt_r <= sqe_cnt_r + SQE_CNT_W'(1);
               end
            end
            default: begin
               // Recover from an illegal code
               sqe_state_r <= SQE_IDLE;
            end
         endcase
      end
   end

   // Not for an underrun frame
   // Fires in the last window cycle, one below the limit
   assign sqe_event = (sqe_state_r == SQE_WAIT) && !mii_in.col && !tx_urun_r
                      && !underrun_event && (sqe_cnt_r == sqe_limit - SQE_CNT_W'(1));

   assign sym_now = sym_r || (mii_in.rx_dv && mii_in.rx_er);

   // Symbol error accumulator, cleared at frame end
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sym_r <= 1'b0;
      end else if (rx_stat_in.frame_end) begin
         // Next frame starts clean
         sym_r <= 1'b0;
      end else begin
         sym_r <= sym_now;
      end
   end

   // Length classes
   // Longer than the selected maximum
   assign rx_long = rx_stat_in.length > len_max;
   // Shorter than the minimum frame
   assign rx_short = rx_stat_in.length < LEN_MIN;
   // Inside the valid range, both ends included
   assign rx_valid_len = !rx_long && !rx_short;
   // Any of CRC, alignment or symbol error
   assign rx_bad = rx_stat_in.crc_err || rx_stat_in.align_err || sym_now;

   // Increment requests
   always_comb begin
      inc = '0;
      // Transmit underrun
      inc[IDX_TX_UNDERRUN] = underrun_event;
      // Carrier error feeds one counter only
      inc[IDX_CARRIER_ERR] = carrier_err_event;
      // Missing heartbeat
      inc[IDX_SQE_TEST] = sqe_event;
      // Receive counters only at frame end
      if (rx_stat_in.frame_end) begin
         inc[IDX_RX_RESOURCE] = rx_stat_in.addr_match && rx_stat_in.no_buffer;
         inc[IDX_RX_OVERRUN] = rx_stat_in.addr_match && rx_stat_in.overrun;
         inc[IDX_RX_SYMBOL] = sym_now;
         inc[IDX_EXCESS_LEN] = rx_long && !rx_bad;
         inc[IDX_RX_JABBER] = rx_long && rx_bad;
         inc[IDX_UNDERSIZE] = rx_short && !rx_bad;
      end
   end

   // Valid-length symbol error routed by alignment
   assign fcs_inc_nxt = rx_stat_in.frame_end && rx_valid_len && sym_now
                        && !rx_stat_in.align_err && !rx_stat_in.crc_err;
   // Alignment route takes any such frame with a partial byte
   assign align_inc_nxt = rx_stat_in.frame_end && rx_valid_len && sym_now
                          && rx_stat_in.align_err;

   // Registered requests to the neighbouring counters
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         fcs_err_inc_out <= 1'b0;
         align_err_inc_out <= 1'b0;
      end else begin
         fcs_err_inc_out <= fcs_inc_nxt;
         align_err_inc_out <= align_inc_nxt;
      end
   end

   // Counters: a bus write loads, otherwise count and wrap
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            cnt_r[i] <= CNT_RESET;
         end
      end else begin
         for (int i = 0; i < NUM_CNT; i++) begin
            if (apb_wr && addr_hit && word_idx == 4'(i)) begin
               cnt_r[i] <= pwdata_in[15:0] & cnt_mask(i);
            end else if (inc[i]) begin
               // Wraps at the counter's own width
               cnt_r[i] <= (cnt_r[i] + 16'h0001) & cnt_mask(i);
            end
         end
      end
   end

   // Sticky status: set wins over read-clear
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         int_stat_r <= INT_RESET;
      end else if (apb_rd && addr_hit && paddr_in == OFF_INT_STATUS) begin
         // Read clears, but events of this cycle stay set
         int_stat_r <= inc;
      end else begin
         // Accumulate events
         int_stat_r <= int_stat_r | inc;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         int_mask_r <= INT_RESET;
      end else if (apb_wr && addr_hit && paddr_in == OFF_INT_MASK) begin
         int_mask_r <= pwdata_in[8:0];
      end
   end

   // Level interrupt from a flop
   always_ff @(posedge clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_out <= 1'b0;
      end else begin
         // High while any unmasked status bit is set
         irq_out <= |(int_stat_r & int_mask_r);
      end
   end

   // Read mux, unused upper bits zero
   always_comb begin
      prdata_out = 32'h0000_0000;
      if (apb_rd && addr_hit) begin
         if (word_idx < 4'(NUM_CNT)) begin
            prdata_out = {16'h0000, cnt_r[word_idx]};
         end else if (paddr_in == OFF_CONFIG) begin
            // Configuration word
            prdata_out = cfg_r;
         end else if (paddr_in == OFF_INT_STATUS) begin
            // Sticky event bits
            prdata_out = {23'h000000, int_stat_r};
         end else begin
            // Only the mask register is left
            prdata_out = {23'h000000, int_mask_r};
         end
      end
   end
endmodule : mesc_top
`default_nettype wire

// >>> mesc_top_monitor.sv
`default_nettype none
module mesc_top_monitor import mesc_pkg::*; (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire mesc_pkg::mesc_rx_stat_t rx_stat_in,
   input wire logic fcs_err_inc_out,
   input wire logic align_err_inc_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // Access phase and bad-address decode
   logic acc;
   logic bad;
   logic rd_ok;
   assign acc = psel_in & penable_in;
   assign bad = (paddr_in > OFF_INT_MASK) || (paddr_in[1:0] != 2'b00);
   assign rd_ok = acc && !pwrite_in && !bad;

   a_ready_high: assert property (pready_out)
      else $error("pready low");
   a_refuse_bad: assert property (acc && bad |-> pslverr_out && prdata_out == 32'h0)
      else $error("bad address not refused");
   a_accept_good: assert property (acc && !bad |-> !pslverr_out)
      else $error("good address refused");
   a_idle_quiet: assert property (!acc |-> prdata_out == 32'h0 && !pslverr_out)
      else $error("bus outputs busy outside access");
   a_narrow_upper: assert property (rd_ok && paddr_in <= OFF_SQE_TEST_ERROR_COUNT &&
      paddr_in != OFF_RX_RESOURCE_ERROR_COUNT |-> prdata_out[31:8] == 24'h0)
      else $error("narrow counter upper bits set");
   a_wide_upper: assert property (rd_ok && paddr_in == OFF_RX_RESOURCE_ERROR_COUNT
      |-> prdata_out[31:16] == 16'h0)
      else $error("wide counter upper bits set");
   a_fcs_cause: assert property (fcs_err_inc_out |-> $past(rx_stat_in.frame_end) &&
      !$past(rx_stat_in.crc_err) && !$past(rx_stat_in.align_err) &&
      $past(rx_stat_in.length) >= LEN_MIN)
      else $error("fcs pulse without cause");
   a_align_cause: assert property (align_err_inc_out |-> $past(rx_stat_in.frame_end) &&
      $past(rx_stat_in.align_err) && $past(rx_stat_in.length) >= LEN_MIN)
      else $error("align pulse without cause");
   a_long_nopulse: assert property (rx_stat_in.frame_end &&
      rx_stat_in.length > LEN_MAX_BIG |=> !fcs_err_inc_out && !align_err_inc_out)
      else $error("overlong frame routed as fcs");
   a_short_nopulse: assert property (rx_stat_in.frame_end &&
      rx_stat_in.length < LEN_MIN |=> !fcs_err_inc_out && !align_err_inc_out)
      else $error("short frame routed as fcs");
endmodule : mesc_top_monitor

bind mesc_top mesc_top_monitor mon_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .rx_stat_in(rx_stat_in),
   .fcs_err_inc_out(fcs_err_inc_out), .align_err_inc_out(align_err_inc_out));
`default_nettype wire

// >>> mesc_top_test.sv
`default_nettype none
module mesc_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   import mesc_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, tx_en, crs, col, rx_dv, rx_er;
   logic rx_go, rx_bad, sqe_col, pready, pslverr, fcs_o, al_o, irq, e;
   logic [1:0] crs_mode;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   mesc_tx_stat_t tx_st;
   mesc_rx_stat_t rx_st;
   logic [15:0] ex [NUM_CNT]; // Expected counter values
   int failures = 0;
   int cmp_count = 0;
   int n_fcs = 0;
   int n_al = 0;
   int x_fcs = 0;
   int x_al = 0;

   mesc_top dut_u (.clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .mii_in({tx_en, crs, col, rx_dv, rx_er}),
      .tx_stat_in(tx_st), .rx_stat_in(rx_st), .fcs_err_inc_out(fcs_o),
      .align_err_inc_out(al_o), .irq_out(irq));
   mesc_phy_model phy_u (.clk_in(clk), .rst_n_in(rst_n), .tx_en_in(tx_en),
      .crs_mode_in(crs_mode), .sqe_col_in(sqe_col), .rx_go_in(rx_go), .rx_bad_in(rx_bad),
      .crs_out(crs), .col_out(col), .rx_dv_out(rx_dv), .rx_er_out(rx_er));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Count routing pulses
   always @(posedge clk) begin
      if (fcs_o === 1'b1) n_fcs++;
      if (al_o === 1'b1) n_al++;
   end

   task automatic conclude;
      $display("Compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      cmp_count++;
      if (s !== x) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, x, s);
      end
   endtask : chk

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         failures++;
         conclude();
      end
   endtask : apb

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, q, x);
   endtask : rd

   task automatic check_all;
      for (int i = 0; i < NUM_CNT; i++) begin
         rd($sformatf("count%0d", i), 8'(4 * i), {16'h0, ex[i]});
      end
   endtask : check_all

   task automatic tx_frame(input logic un, input logic [1:0] cm, input logic cl);
      @(posedge clk);
      crs_mode <= cm;
      sqe_col <= cl;
      tx_en <= 1'b1;
      repeat (4) @(posedge clk);
      tx_en <= 1'b0;
      tx_st <= '{1'b1, un};
      @(posedge clk);
      tx_st <= '0;
      repeat (SQE_CYC_100 + 8) @(posedge clk);
   endtask : tx_frame

   // Flags are {crc, align, symbol, match, no_buffer, overrun, big}
   task automatic rx_frame(input int len, input logic [6:0] f);
      @(posedge clk);
      rx_go <= 1'b1;
      rx_bad <= f[4];
      repeat (3) @(posedge clk);
      rx_st <= '{1'b1, f[3], f[2], f[1], f[6], f[5], 14'(len)};
      @(posedge clk);
      rx_st <= '0;
      rx_go <= 1'b0;
      rx_bad <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : rx_frame

   task automatic test_regs;
      check_all();
      apb(1'b1, OFF_RX_RESOURCE_ERROR_COUNT, 32'hffff_ffff);
      rd("resource", OFF_RX_RESOURCE_ERROR_COUNT, 32'h0000_ffff);
      apb(1'b1, OFF_TX_UNDERRUN_COUNT, 32'h0000_01ab);
      rd("underrun", OFF_TX_UNDERRUN_COUNT, 32'h0000_00ab);
      apb(1'b1, OFF_RX_RESOURCE_ERROR_COUNT, 32'h0);
      apb(1'b1, OFF_TX_UNDERRUN_COUNT, 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      chk("slverr", {31'h0, e}, 32'h1);
      chk("unmapped", q, 32'h0);
   endtask : test_regs

   task automatic test_tx;
      // Rows are {full_duplex, underrun, carrier mode, heartbeat}
      logic [4:0] rows [6] = '{5'b01000, 5'b00001, 5'b00101, 5'b00011, 5'b00010, 5'b10000};
      logic [4:0] r;
      for (int i = 0; i < 6; i++) begin
         r = rows[i];
         apb(1'b1, OFF_CONFIG, {30'h0, 1'b1, r[4]});
         tx_frame(r[3], r[2:1], r[0]);
         if (r[3]) begin
            ex[IDX_TX_UNDERRUN]++;
         end else if (!r[4]) begin
            if (r[2:1] != 2'b01) ex[IDX_CARRIER_ERR]++;
            if (!r[0]) ex[IDX_SQE_TEST]++;
         end
         check_all();
      end
   endtask : test_tx

   task automatic test_rx;
      int lens [14] = '{100, 100, 1519, 1519, 1536, 1537, 1537, 63, 64, 63, 100, 100, 100, 1518};
      logic [6:0] fl [14] = '{7'h10, 7'h30, 7'h00, 7'h10, 7'h01, 7'h01, 7'h41, 7'h00, 7'h00,
         7'h40, 7'h0c, 7'h0a, 7'h06, 7'h10};
      logic [6:0] f;
      logic cl, lg, ok;
      int mx;
      for (int i = 0; i < 14; i++) begin
         f = fl[i];
         mx = f[0] ? 1536 : 1518;
         apb(1'b1, OFF_CONFIG, {23'h0, f[0], 8'h02});
         rx_frame(lens[i], f);
         cl = !(f[6] | f[5] | f[4]);
         lg = lens[i] > mx;
         ok = !lg && lens[i] >= 64 && f[4];
         ex[IDX_RX_SYMBOL] += f[4];
         ex[IDX_RX_RESOURCE] += f[3] & f[2];
         ex[IDX_RX_OVERRUN] += f[3] & f[1];
         ex[IDX_EXCESS_LEN] += lg & cl;
         ex[IDX_RX_JABBER] += lg & !cl;
         ex[IDX_UNDERSIZE] += (lens[i] < 64) & cl;
         x_fcs += ok & !f[5] & !f[6];
         x_al += ok & f[5];
      end
      check_all();
      chk("fcs pulses", n_fcs, x_fcs);
      chk("align pulses", n_al, x_al);
   endtask : test_rx

   task automatic test_irq;
      apb(1'b0, OFF_INT_STATUS, 32'h0);
      apb(1'b1, OFF_CONFIG, 32'h2);
      tx_frame(1'b1, 2'b00, 1'b0);
      @(negedge clk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      rd("status", OFF_INT_STATUS, 32'h1);
      rd("status cleared", OFF_INT_STATUS, 32'h0);
      apb(1'b1, OFF_INT_MASK, 32'h1);
      tx_frame(1'b1, 2'b00, 1'b0);
      @(negedge clk);
      chk("irq", {31'h0, irq}, 32'h1);
      rd("status", OFF_INT_STATUS, 32'h1);
      repeat (2) @(negedge clk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      ex[IDX_TX_UNDERRUN] += 2;
      check_all();
   endtask : test_irq

   // Heartbeat window at the slow line rate
   task automatic test_slow;
      apb(1'b1, OFF_CONFIG, 32'h0);
      tx_frame(1'b0, 2'b01, 1'b0);
      rd("sqe early", OFF_SQE_TEST_ERROR_COUNT, {16'h0, ex[IDX_SQE_TEST]});
      repeat (SQE_CYC_10) @(posedge clk);
      ex[IDX_SQE_TEST]++;
      check_all();
   endtask : test_slow

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      tx_en = 1'b0;
      tx_st = '0;
      rx_st = '0;
      rx_go = 1'b0;
      rx_bad = 1'b0;
      crs_mode = 2'b00;
      sqe_col = 1'b0;
      ex = '{default: 16'h0};
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      test_regs();
      test_tx();
      test_rx();
      test_slow();
      test_irq();
      conclude();
   end
endmodule : mesc_top_test
`default_nettype wire
